// File: core/pts_defs.svh
// constants and bit positions of the port traffic statistics block
`ifndef PTS_DEFS_SVH
`define PTS_DEFS_SVH

// ----------------------------------------------------------------
// counter layout
// ----------------------------------------------------------------
`define PTS_CNT_RESET 32'h00000000
`define PTS_NUM_BINS 6
`define PTS_CNT_TX_OCTETS 0
`define PTS_CNT_NET_OCTETS 1
`define PTS_CNT_HIST0 2

// ----------------------------------------------------------------
// size bucket positions and bounds
// ----------------------------------------------------------------
`define PTS_BIN_64 0
`define PTS_BIN_65_127 1
`define PTS_BIN_128_255 2
`define PTS_BIN_256_511 3
`define PTS_BIN_512_1023 4
`define PTS_BIN_1024_UP 5
`define PTS_LEN_64 16'h0040
`define PTS_LEN_128 16'h0080
`define PTS_LEN_256 16'h0100
`define PTS_LEN_512 16'h0200
`define PTS_LEN_1024 16'h0400

// ----------------------------------------------------------------
// collision timing
// ----------------------------------------------------------------
`define PTS_SLOT_BITS 512
`define PTS_BITS_PER_BYTE 8
`define PTS_COLL_LIMIT 16

`endif

// File: core/pts_pkg.sv
// types shared by the port traffic statistics modules
package pts_pkg;

	// transmit attempt tracker, one-hot
	typedef enum logic [1:0] {
		pts_tx_idle = 2'b01,
		pts_tx_retry = 2'b10
	} pts_tx_state_type;

	typedef logic [4:0] pts_coll_cnt_type;

endpackage

// File: core/pts_cnt_if.sv
// add request and value of one statistics counter
`timescale 1ns/10ps
`default_nettype none

interface pts_cnt_if #(parameter int CNT_W = 32) ();
	logic add_en;
	logic [CNT_W-1:0] amount;
	logic [CNT_W-1:0] value;

	modport owner (output add_en, output amount, input value);
	modport counter (input add_en, input amount, output value);
endinterface

`default_nettype wire

// File: core/pts_counter.sv
// one wrapping statistics counter
`timescale 1ns/10ps
`default_nettype none
`include "pts_defs.svh"

module pts_counter #(
	parameter int CNT_W = 32
) (
	input wire logic clk_sys,
	input wire logic rst,
	pts_cnt_if.counter bus
);

	logic [CNT_W-1:0] value_reg;
	logic [CNT_W-1:0] value_next;

	// whole amount in one step; carry out dropped so the count wraps
	assign value_next = bus.add_en ? value_reg + bus.amount : value_reg;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			value_reg <= CNT_W'(`PTS_CNT_RESET);
		end else begin
			value_reg <= value_next;
		end
	end

	assign bus.value = value_reg;

	property p_cnt_add;
		@(posedge clk_sys) disable iff (rst)
		bus.add_en |=> bus.value == CNT_W'($past(bus.value) + $past(bus.amount));
	endproperty
	a_cnt_add: assert property (p_cnt_add) else $error("counter did not add amount");

endmodule

`default_nettype wire

// File: core/pts_size_bin.sv
// sorts one frame length into the six size buckets
`timescale 1ns/10ps
`default_nettype none
`include "pts_defs.svh"

module pts_size_bin #(
	parameter int LEN_W = 16
) (
	input wire logic [LEN_W-1:0] frame_len,
	input wire logic [LEN_W-1:0] max_rx_frame_length,
	input wire logic is_rx,
	input wire logic qualify,
	output logic [`PTS_NUM_BINS-1:0] bin_hit
);

	// frames below 64 bytes fall in no bucket
	always_comb begin
		bin_hit = '0;
		if (qualify) begin
			bin_hit[`PTS_BIN_64] = frame_len == LEN_W'(`PTS_LEN_64);
			bin_hit[`PTS_BIN_65_127] = frame_len > LEN_W'(`PTS_LEN_64)
				&& frame_len < LEN_W'(`PTS_LEN_128);
			bin_hit[`PTS_BIN_128_255] = frame_len >= LEN_W'(`PTS_LEN_128)
				&& frame_len < LEN_W'(`PTS_LEN_256);
			bin_hit[`PTS_BIN_256_511] = frame_len >= LEN_W'(`PTS_LEN_256)
				&& frame_len < LEN_W'(`PTS_LEN_512);
			bin_hit[`PTS_BIN_512_1023] = frame_len >= LEN_W'(`PTS_LEN_512)
				&& frame_len < LEN_W'(`PTS_LEN_1024);
			// receive is capped by the configured maximum, transmit is open ended
			bin_hit[`PTS_BIN_1024_UP] = frame_len >= LEN_W'(`PTS_LEN_1024)
				&& (!is_rx || frame_len <= max_rx_frame_length);
		end
	end

endmodule

`default_nettype wire

// File: core/pts_stats.sv
// port traffic statistics: byte counters and frame size histogram
`timescale 1ns/10ps
`default_nettype none
`include "pts_defs.svh"

module pts_stats #(
	parameter int LEN_W = 16,
	parameter int CNT_W = 32
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic half_duplex,
	input wire logic [LEN_W-1:0] max_rx_frame_length,
	input wire logic tx_attempt_end,
	input wire logic [LEN_W-1:0] tx_attempt_bytes,
	input wire logic tx_collision,
	input wire logic tx_carrier_loss,
	input wire logic tx_underrun,
	input wire logic rx_frame_end,
	input wire logic [LEN_W-1:0] rx_frame_bytes,
	input wire logic rx_flow_jam,
	input wire logic [LEN_W-1:0] rx_jam_bytes,
	output logic [CNT_W-1:0] tx_octets_count,
	output logic [CNT_W-1:0] net_octets_count,
	output logic [`PTS_NUM_BINS-1:0][CNT_W-1:0] hist_count,
	output logic tx_late_coll,
	output logic tx_excess_coll,
	output logic [4:0] tx_retry_count
);

	// ----------------------------------------------------------------
	// constants
	// ----------------------------------------------------------------
	localparam int NUM_CNT = `PTS_NUM_BINS + 2;
	// 512 bit times expressed in bytes on the wire
	localparam logic [LEN_W-1:0] LATE_BYTES = LEN_W'(`PTS_SLOT_BITS / `PTS_BITS_PER_BYTE);
	localparam pts_pkg::pts_coll_cnt_type LAST_RETRY = 5'(`PTS_COLL_LIMIT - 1);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	pts_pkg::pts_tx_state_type tx_state_reg;
	pts_pkg::pts_tx_state_type tx_state_next;
	pts_pkg::pts_coll_cnt_type coll_cnt_reg;
	pts_pkg::pts_coll_cnt_type coll_cnt_next;
	logic late_reg;
	logic excess_reg;
	logic coll_any;
	logic coll_late;
	logic coll_early;
	logic coll_excess;
	logic tx_done;
	logic tx_good;
	logic tx_hist_ok;
	logic [LEN_W-1:0] rx_net_bytes;
	logic [LEN_W:0] net_amt_next;
	logic [LEN_W:0] net_amt_reg;
	logic net_en_reg;
	logic [LEN_W-1:0] tx_oct_amt_reg;
	logic tx_oct_en_reg;
	logic [`PTS_NUM_BINS-1:0] rx_bin;
	logic [`PTS_NUM_BINS-1:0] tx_bin;
	logic [`PTS_NUM_BINS-1:0][1:0] bin_amt_next;
	logic [`PTS_NUM_BINS-1:0][1:0] bin_amt_reg;

	// ----------------------------------------------------------------
	// transmit attempt classification
	// ----------------------------------------------------------------
	// a collision past the slot time is late and ends the frame for good
	assign coll_any = tx_attempt_end && tx_collision;
	assign coll_late = coll_any && (tx_attempt_bytes > LATE_BYTES);
	assign coll_early = coll_any && !coll_late;
	// the sixteenth early collision abandons the frame
	assign coll_excess = coll_early && (coll_cnt_reg == LAST_RETRY);
	// an attempt without collision finishes the frame, carrier loss included
	assign tx_done = tx_attempt_end && !tx_collision;
	assign tx_good = tx_done && !tx_carrier_loss && !tx_underrun;
	// carrier loss keeps a frame out of the buckets unless it is exactly 64 bytes
	assign tx_hist_ok = tx_done
		&& (!tx_carrier_loss || tx_attempt_bytes == LEN_W'(`PTS_LEN_64));
	// late and excessive frames never reach tx_done, so they skip the buckets

	// retry tracker: stays in retry while early collisions pile up
	always_comb begin
		tx_state_next = tx_state_reg;
		coll_cnt_next = coll_cnt_reg;
		case (tx_state_reg)
			pts_pkg::pts_tx_idle: begin
				if (coll_early && !coll_excess) begin
					tx_state_next = pts_pkg::pts_tx_retry;
					coll_cnt_next = 5'h01;
				end
			end
			pts_pkg::pts_tx_retry: begin
				if (coll_early && !coll_excess) begin
					coll_cnt_next = coll_cnt_reg + 5'h01;
				end else if (tx_attempt_end) begin
					// done, late or excessive: the next attempt is a new frame
					tx_state_next = pts_pkg::pts_tx_idle;
					coll_cnt_next = 5'h00;
				end
			end
			default: begin
				tx_state_next = pts_pkg::pts_tx_idle;
				coll_cnt_next = 5'h00;
			end
		endcase
	end

	// tracker state
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tx_state_reg <= pts_pkg::pts_tx_idle;
			coll_cnt_reg <= 5'h00;
		end else begin
			tx_state_reg <= tx_state_next;
			coll_cnt_reg <= coll_cnt_next;
		end
	end

	// abandon indications, one cycle each
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			late_reg <= 1'b0;
			excess_reg <= 1'b0;
		end else begin
			late_reg <= coll_late;
			excess_reg <= coll_excess;
		end
	end

	// ----------------------------------------------------------------
	// byte amounts
	// ----------------------------------------------------------------
	// in half duplex a flow-control jam counts rx_jam_bytes in place of rx_frame_bytes, cutting the frame at the jam point
	assign rx_net_bytes = (half_duplex && rx_flow_jam) ? rx_jam_bytes : rx_frame_bytes;
	// every attempt counts, errors or not, so retries add their partial bytes again
	always_comb begin
		net_amt_next = '0;
		if (rx_frame_end) begin
			net_amt_next = net_amt_next + {1'b0, rx_net_bytes};
		end
		if (tx_attempt_end) begin
			net_amt_next = net_amt_next + {1'b0, tx_attempt_bytes};
		end
	end
	// carrier loss still reaches the net count through tx_attempt_end
	// no error input gates the net amount

	// staged so the counters see one registered request per cycle
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			net_en_reg <= 1'b0;
			net_amt_reg <= '0;
			tx_oct_en_reg <= 1'b0;
			tx_oct_amt_reg <= '0;
		end else begin
			net_en_reg <= rx_frame_end || tx_attempt_end;
			net_amt_reg <= net_amt_next;
			tx_oct_en_reg <= tx_good;
			tx_oct_amt_reg <= tx_good ? tx_attempt_bytes : '0;
		end
	end

	// ----------------------------------------------------------------
	// size buckets
	// ----------------------------------------------------------------
	pts_size_bin #(.LEN_W(LEN_W)) u_rx_bin (
		.frame_len(rx_frame_bytes),
		.max_rx_frame_length(max_rx_frame_length),
		.is_rx(1'b1),
		.qualify(rx_frame_end),
		.bin_hit(rx_bin)
	);

	pts_size_bin #(.LEN_W(LEN_W)) u_tx_bin (
		.frame_len(tx_attempt_bytes),
		.max_rx_frame_length(max_rx_frame_length),
		.is_rx(1'b0),
		.qualify(tx_hist_ok),
		.bin_hit(tx_bin)
	);

	// a receive and a transmit can end together and land in the same bucket
	always_comb begin
		for (int b = 0; b < `PTS_NUM_BINS; b++) begin
			bin_amt_next[b] = {1'b0, rx_bin[b]} + {1'b0, tx_bin[b]};
		end
	end
	// tx_hist_ok keeps collisions, and carrier loss other than at 64 bytes, out of the transmit buckets; underrun is not gated and still reaches them

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			bin_amt_reg <= '0;
		end else begin
			bin_amt_reg <= bin_amt_next;
		end
	end

	// ----------------------------------------------------------------
	// counters
	// ----------------------------------------------------------------
	pts_cnt_if #(.CNT_W(CNT_W)) cnt_bus [NUM_CNT] ();

	genvar g;
	for (g = 0; g < NUM_CNT; g++) begin : gen_cnt
		pts_counter #(.CNT_W(CNT_W)) u_cnt (
			.clk_sys(clk_sys),
			.rst(rst),
			.bus(cnt_bus[g])
		);
	end

	assign cnt_bus[`PTS_CNT_TX_OCTETS].add_en = tx_oct_en_reg;
	assign cnt_bus[`PTS_CNT_TX_OCTETS].amount = CNT_W'(tx_oct_amt_reg);
	assign cnt_bus[`PTS_CNT_NET_OCTETS].add_en = net_en_reg;
	assign cnt_bus[`PTS_CNT_NET_OCTETS].amount = CNT_W'(net_amt_reg);

	for (g = 0; g < `PTS_NUM_BINS; g++) begin : gen_bin
		assign cnt_bus[`PTS_CNT_HIST0 + g].add_en = bin_amt_reg[g] != 2'h0;
		assign cnt_bus[`PTS_CNT_HIST0 + g].amount = CNT_W'(bin_amt_reg[g]);
		assign hist_count[g] = cnt_bus[`PTS_CNT_HIST0 + g].value;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign tx_octets_count = cnt_bus[`PTS_CNT_TX_OCTETS].value;
	assign net_octets_count = cnt_bus[`PTS_CNT_NET_OCTETS].value;
	assign tx_late_coll = late_reg;
	assign tx_excess_coll = excess_reg;
	assign tx_retry_count = coll_cnt_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_tx_good_adds;
		@(posedge clk_sys) disable iff (rst)
		tx_attempt_end && !tx_collision && !tx_carrier_loss && !tx_underrun
		|-> ##2 tx_octets_count == CNT_W'($past(tx_octets_count)
			+ CNT_W'($past(tx_attempt_bytes, 2)));
	endproperty
	a_tx_good_adds: assert property (p_tx_good_adds)
		else $error("good frame not added to transmit bytes");

	property p_tx_bad_skips;
		@(posedge clk_sys) disable iff (rst)
		tx_attempt_end && (tx_collision || tx_carrier_loss || tx_underrun)
		|-> ##2 $stable(tx_octets_count);
	endproperty
	a_tx_bad_skips: assert property (p_tx_bad_skips)
		else $error("bad frame added to transmit bytes");

	property p_net_rx;
		@(posedge clk_sys) disable iff (rst)
		rx_frame_end && !tx_attempt_end && !(half_duplex && rx_flow_jam)
		|-> ##2 net_octets_count == CNT_W'($past(net_octets_count)
			+ CNT_W'($past(rx_frame_bytes, 2)));
	endproperty
	a_net_rx: assert property (p_net_rx)
		else $error("received bytes missing from net count");

	property p_net_carrier;
		@(posedge clk_sys) disable iff (rst)
		tx_attempt_end && tx_carrier_loss && !rx_frame_end
		|-> ##2 net_octets_count == CNT_W'($past(net_octets_count)
			+ CNT_W'($past(tx_attempt_bytes, 2)));
	endproperty
	a_net_carrier: assert property (p_net_carrier)
		else $error("carrier loss bytes missing from net count");

	property p_net_coll;
		@(posedge clk_sys) disable iff (rst)
		coll_any && !rx_frame_end
		|-> ##2 net_octets_count == CNT_W'($past(net_octets_count)
			+ CNT_W'($past(tx_attempt_bytes, 2)));
	endproperty
	a_net_coll: assert property (p_net_coll)
		else $error("collision attempt bytes missing from net count");

	property p_net_jam;
		@(posedge clk_sys) disable iff (rst)
		rx_frame_end && half_duplex && rx_flow_jam && !tx_attempt_end
		|-> ##2 net_octets_count == CNT_W'($past(net_octets_count)
			+ CNT_W'($past(rx_jam_bytes, 2)));
	endproperty
	a_net_jam: assert property (p_net_jam)
		else $error("jammed receive not cut at jam point");

	property p_bin64_tx;
		@(posedge clk_sys) disable iff (rst)
		tx_done && tx_attempt_bytes == LEN_W'(`PTS_LEN_64) && !rx_frame_end
		|-> ##2 hist_count[`PTS_BIN_64] == CNT_W'($past(hist_count[`PTS_BIN_64]) + 1);
	endproperty
	a_bin64_tx: assert property (p_bin64_tx)
		else $error("64 byte transmit frame not counted");

	property p_late_skips_bins;
		@(posedge clk_sys) disable iff (rst)
		coll_any && !rx_frame_end |-> ##2 $stable(hist_count);
	endproperty
	a_late_skips_bins: assert property (p_late_skips_bins)
		else $error("collided attempt reached a size bucket");

	property p_bin_65_127;
		@(posedge clk_sys) disable iff (rst)
		rx_frame_end && !tx_attempt_end && rx_frame_bytes > LEN_W'(`PTS_LEN_64)
		&& rx_frame_bytes < LEN_W'(`PTS_LEN_128)
		|-> ##2 hist_count[`PTS_BIN_65_127]
			== CNT_W'($past(hist_count[`PTS_BIN_65_127]) + 1);
	endproperty
	a_bin_65_127: assert property (p_bin_65_127)
		else $error("65 to 127 byte frame not counted");

	property p_rx_over_max;
		@(posedge clk_sys) disable iff (rst)
		rx_frame_end && !tx_attempt_end && rx_frame_bytes > max_rx_frame_length
		|-> ##2 $stable(hist_count[`PTS_BIN_1024_UP]);
	endproperty
	a_rx_over_max: assert property (p_rx_over_max)
		else $error("oversize receive counted in top bucket");

	property p_late_flag;
		@(posedge clk_sys) disable iff (rst)
		coll_any && tx_attempt_bytes > LATE_BYTES |=> tx_late_coll && tx_retry_count == 5'h00;
	endproperty
	a_late_flag: assert property (p_late_flag)
		else $error("late collision not flagged");

	property p_excess_flag;
		@(posedge clk_sys) disable iff (rst)
		coll_any && tx_attempt_bytes <= LATE_BYTES && tx_retry_count == LAST_RETRY
		|=> tx_excess_coll && tx_retry_count == 5'h00;
	endproperty
	a_excess_flag: assert property (p_excess_flag)
		else $error("sixteenth collision not flagged excessive");

	c_excess: cover property (@(posedge clk_sys) disable iff (rst) tx_excess_coll);
	c_late: cover property (@(posedge clk_sys) disable iff (rst) tx_late_coll);
	c_carrier64: cover property (@(posedge clk_sys) disable iff (rst)
		tx_done && tx_carrier_loss && tx_attempt_bytes == LEN_W'(`PTS_LEN_64));
	c_both_end: cover property (@(posedge clk_sys) disable iff (rst)
		rx_frame_end && tx_attempt_end);

endmodule

`default_nettype wire

// File: dv/pts_mac_model.sv
// behavioural model of the port's transmit and receive paths
`timescale 1ns/10ps
`default_nettype none

module pts_mac_model (
	input wire logic clk_sys,
	output logic tx_attempt_end,
	output logic [15:0] tx_attempt_bytes,
	output logic tx_collision,
	output logic tx_carrier_loss,
	output logic tx_underrun,
	output logic rx_frame_end,
	output logic [15:0] rx_frame_bytes,
	output logic rx_flow_jam,
	output logic [15:0] rx_jam_bytes
);
	// quiet lines at time zero
	initial begin
		{tx_attempt_end, tx_collision, tx_carrier_loss, tx_underrun} = 4'h0;
		{rx_frame_end, rx_flow_jam} = 2'h0;
		{tx_attempt_bytes, rx_frame_bytes, rx_jam_bytes} = 48'h0;
	end

	// ----------------------------------------------------------------
	// one frame end on either path, or both in the same cycle
	// ----------------------------------------------------------------
	// qualifiers are inverted after the pulse so a stale value never looks valid
	task automatic send(input logic t, input logic [15:0] tb, input logic c, input logic l,
		input logic u, input logic r, input logic [15:0] rb, input logic j,
		input logic [15:0] jb);
		@(posedge clk_sys);
		tx_attempt_end <= t;
		tx_attempt_bytes <= tb;
		{tx_collision, tx_carrier_loss, tx_underrun} <= {c, l, u};
		rx_frame_end <= r;
		rx_frame_bytes <= rb;
		rx_flow_jam <= j;
		rx_jam_bytes <= jb;
		@(posedge clk_sys);
		tx_attempt_end <= 1'b0;
		rx_frame_end <= 1'b0;
		tx_attempt_bytes <= ~tb;
		rx_frame_bytes <= ~rb;
		rx_jam_bytes <= ~jb;
		{tx_collision, tx_carrier_loss, tx_underrun, rx_flow_jam} <= ~{c, l, u, j};
	endtask
endmodule

`default_nettype wire

// File: dv/pts_stats_tb.sv
// self-checking testbench of the port traffic statistics block
`timescale 1ns/10ps
`default_nettype none

module pts_stats_tb;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic half_duplex = 1'b0;
	logic [15:0] max_rx_frame_length = 16'h05EE;
	logic tx_attempt_end, tx_collision, tx_carrier_loss, tx_underrun;
	logic rx_frame_end, rx_flow_jam;
	logic [15:0] tx_attempt_bytes, rx_frame_bytes, rx_jam_bytes;
	logic [31:0] tx_octets_count, net_octets_count;
	logic [5:0][31:0] hist_count;
	logic tx_late_coll, tx_excess_coll;
	logic [4:0] tx_retry_count;
	logic [31:0] exp_tx = 32'h0, exp_net = 32'h0;
	logic [31:0] exp_hist [6];
	logic [4:0] exp_retry = 5'h0;
	logic exp_late, exp_exc;
	int bad_count = 0, n_tests = 0, cyc = 0;

	always #25 clk_sys = ~clk_sys;

	pts_mac_model mac (.clk_sys(clk_sys), .tx_attempt_end(tx_attempt_end),
		.tx_attempt_bytes(tx_attempt_bytes), .tx_collision(tx_collision),
		.tx_carrier_loss(tx_carrier_loss), .tx_underrun(tx_underrun),
		.rx_frame_end(rx_frame_end), .rx_frame_bytes(rx_frame_bytes),
		.rx_flow_jam(rx_flow_jam), .rx_jam_bytes(rx_jam_bytes));

	pts_stats DUT (.clk_sys(clk_sys), .rst(rst), .half_duplex(half_duplex),
		.max_rx_frame_length(max_rx_frame_length), .tx_attempt_end(tx_attempt_end),
		.tx_attempt_bytes(tx_attempt_bytes), .tx_collision(tx_collision),
		.tx_carrier_loss(tx_carrier_loss), .tx_underrun(tx_underrun),
		.rx_frame_end(rx_frame_end), .rx_frame_bytes(rx_frame_bytes),
		.rx_flow_jam(rx_flow_jam), .rx_jam_bytes(rx_jam_bytes),
		.tx_octets_count(tx_octets_count), .net_octets_count(net_octets_count),
		.hist_count(hist_count), .tx_late_coll(tx_late_coll),
		.tx_excess_coll(tx_excess_coll), .tx_retry_count(tx_retry_count));

	// ----------------------------------------------------------------
	// comparison, expectation and transfer helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_tests++;
		if (seen !== want) begin
			bad_count++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask

	// size bucket of a frame, 6 means none
	function automatic int bin_of(input logic [15:0] len, input logic is_rx);
		if (len < 16'h0040) return 6;
		if (len == 16'h0040) return 0;
		if (len < 16'h0080) return 1;
		if (len < 16'h0100) return 2;
		if (len < 16'h0200) return 3;
		if (len < 16'h0400) return 4;
		if (is_rx && len > max_rx_frame_length) return 6;
		return 5;
	endfunction

	task automatic tx_exp(input logic [15:0] b, input logic c, input logic l, input logic u);
		int k;
		exp_late = c && b > 16'h0040;
		exp_exc = c && !exp_late && exp_retry == 5'h0F;
		exp_net += 32'(b);
		if (!c && !l && !u) exp_tx += 32'(b);
		k = l ? ((b == 16'h0040) ? 0 : 6) : bin_of(b, 1'b0);
		if (!c && k < 6) exp_hist[k] += 32'h1;
		exp_retry = (c && !exp_late && !exp_exc) ? exp_retry + 5'h1 : 5'h0;
	endtask

	task automatic rx_exp(input logic [15:0] b, input logic j, input logic [15:0] jb);
		int k;
		exp_net += (half_duplex && j) ? 32'(jb) : 32'(b);
		k = bin_of(b, 1'b1);
		if (k < 6) exp_hist[k] += 32'h1;
	endtask

	// flags stand for the cycle right after the edge that takes the pulse,
	// counters move one edge later and then stand
	task automatic judge();
		#1;
		check(tx_late_coll, exp_late);
		check(tx_excess_coll, exp_exc);
		check(tx_retry_count, exp_retry);
		@(posedge clk_sys);
		#1;
		check(tx_octets_count, exp_tx);
		check(net_octets_count, exp_net);
		for (int i = 0; i < 6; i++) check(hist_count[i], exp_hist[i]);
	endtask

	task automatic tx(input logic [15:0] b, input logic c, input logic l, input logic u);
		tx_exp(b, c, l, u);
		mac.send(1'b1, b, c, l, u, 1'b0, 16'h0, 1'b0, 16'h0);
		judge();
	endtask

	task automatic rx(input logic [15:0] b, input logic j, input logic [15:0] jb);
		{exp_late, exp_exc} = 2'b00;
		rx_exp(b, j, jb);
		mac.send(1'b0, 16'h0, 1'b0, 1'b0, 1'b0, 1'b1, b, j, jb);
		judge();
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	// every bucket edge on transmit, receive around the configured maximum
	task automatic t_bins();
		logic [15:0] txl [13] = '{16'd63, 16'd64, 16'd65, 16'd127, 16'd128, 16'd255,
			16'd256, 16'd511, 16'd512, 16'd1023, 16'd1024, 16'd2000, 16'hFFFF};
		logic [15:0] rxl [5] = '{16'd63, 16'd64, 16'd1024, 16'd1518, 16'd1519};
		foreach (txl[i]) tx(txl[i], 1'b0, 1'b0, 1'b0);
		foreach (rxl[i]) rx(rxl[i], 1'b0, 16'h0);
		$display("bins done");
	endtask

	// early, boundary and late collisions, then sixteen early ones in a row
	task automatic t_coll();
		tx(16'd40, 1'b1, 1'b0, 1'b0);
		tx(16'd64, 1'b1, 1'b0, 1'b0);
		tx(16'd70, 1'b1, 1'b0, 1'b0);
		tx(16'd100, 1'b0, 1'b0, 1'b0);
		for (int i = 0; i < 16; i++) tx(16'd50, 1'b1, 1'b0, 1'b0);
		tx(16'd90, 1'b0, 1'b0, 1'b0);
		$display("collisions done");
	endtask

	// carrier loss at and above 64 bytes, underrun on a good length
	task automatic t_errors();
		tx(16'd64, 1'b0, 1'b1, 1'b0);
		tx(16'd100, 1'b0, 1'b1, 1'b0);
		tx(16'd300, 1'b0, 1'b0, 1'b1);
		$display("errors done");
	endtask

	// jam in half duplex cuts the net count, full duplex ignores it
	task automatic t_jam();
		@(posedge clk_sys);
		half_duplex <= 1'b1;
		// let the mode settle so the expectation reads the new value
		@(posedge clk_sys);
		rx(16'd200, 1'b1, 16'd50);
		@(posedge clk_sys);
		half_duplex <= 1'b0;
		@(posedge clk_sys);
		rx(16'd200, 1'b1, 16'd50);
		$display("jam done");
	endtask

	// both paths ending in one cycle add twice to one bucket
	task automatic t_both();
		{exp_late, exp_exc} = 2'b00;
		tx_exp(16'd64, 1'b0, 1'b0, 1'b0);
		rx_exp(16'd64, 1'b0, 16'h0);
		mac.send(1'b1, 16'd64, 1'b0, 1'b0, 1'b0, 1'b1, 16'd64, 1'b0, 16'h0);
		judge();
		$display("same cycle done");
	endtask

	// ----------------------------------------------------------------
	// closing report and hang guard
	// ----------------------------------------------------------------
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// about 45 frames of three cycles each, so this is generous
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 4000) begin
			bad_count++;
			end_of_test();
		end
	end

	initial begin
		foreach (exp_hist[i]) exp_hist[i] = 32'h0;
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		#1;
		check(net_octets_count, 32'h0);
		t_bins();
		t_coll();
		t_errors();
		t_jam();
		t_both();
		end_of_test();
	end
endmodule

`default_nettype wire
